// >>> vcch_defines.svh
`ifndef VCCH_DEFINES_SVH
`define VCCH_DEFINES_SVH
// Notes on behaviour
// - Private 64KB and 512KB levels, shared 2MB.
// - Shared-level hit moves line; readers may share.
// - Allocation spills victims upward level by level.
// - Shared level filled only by second-level victims.
// - Store-created line is allocated in first level only.
// - Modified sole dirty; exclusive sole clean; invalid empty.
// - Owned line writes memory back on eviction.
// - Store creating an entry allocates it modified.
// - Read of shared modified: owned there, shared copy.
// - Write to owned line waits for probes.
// - Write to shared-level modified line skips probes.
// - Write-intent prefetch moves modified line to first level.
// - Write to migrated line misses, asks memory controller.
`define VCCH_CORES 4
`define VCCH_CORE_W 2
`define VCCH_L1_BYTES 65536
`define VCCH_L2_BYTES 524288
`define VCCH_L3_BYTES 2097152
`define VCCH_LINE_BYTES 64
`define VCCH_LINE_OFF_W 6
`define VCCH_ADDR_W 32
`define VCCH_DATA_W 32
`define VCCH_STATE_W 3
`endif

// >>> vcch_pkg.sv
package vcch_pkg;
  typedef enum logic [2:0] {
    ST_I = 3'h0,
    ST_S = 3'h1,
    ST_E = 3'h2,
    ST_O = 3'h3,
    ST_M = 3'h4
  } vcch_moesi_t;

  typedef enum logic [1:0] {
    OP_LOAD = 2'h0,
    OP_STORE = 2'h1,
    OP_WRITE_INTENT_PREFETCH = 2'h2
  } vcch_op_t;

  // Gray steps along init, lookup, allocate and spill
  typedef enum logic [3:0] {
    S_INIT = 4'h0,
    S_IDLE = 4'h1,
    S_LOOK = 4'h3,
    S_ALLOC = 4'h2,
    S_SPILL2 = 4'h6,
    S_SPILL3 = 4'h7,
    S_MISS = 4'h5,
    S_PROBE = 4'h4,
    S_INVAL = 4'hc
  } vcch_fsm_t;
endpackage

// >>> vcch_line_ram.sv
`timescale 1ns/1ps
module vcch_line_ram #(
  parameter int DEPTH = 1024,
  parameter int WIDTH = 64
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [$clog2(DEPTH)-1:0] addr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // Contents have no reset; the owner sweeps them invalid after reset
  always_ff @(posedge clk_in) begin
    if (en_in && we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (en_in && !we_in) begin
      rdata_q <= mem[addr_in];
    end
  end

  assign rdata_out = rdata_q;
endmodule

// >>> vcch_rst_sync.sv
`timescale 1ns/1ps
module vcch_rst_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  output logic rst_n_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_n_out = sync_q;
endmodule

// >>> vcch_top.sv
`timescale 1ns/1ps
`include "vcch_defines.svh"
module vcch_top #(
  parameter int ADDR_W = `VCCH_ADDR_W,
  parameter int DATA_W = `VCCH_DATA_W,
  parameter int L1_LINES = `VCCH_L1_BYTES / `VCCH_LINE_BYTES,
  parameter int L2_LINES = `VCCH_L2_BYTES / `VCCH_LINE_BYTES,
  parameter int L3_LINES = `VCCH_L3_BYTES / `VCCH_LINE_BYTES
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [`VCCH_CORE_W-1:0] req_core_in,
  input wire vcch_pkg::vcch_op_t req_op_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic rsp_valid_out,
  output logic [`VCCH_CORE_W-1:0] rsp_core_out,
  output logic [DATA_W-1:0] rsp_data_out,
  output vcch_pkg::vcch_moesi_t rsp_state_out,
  output logic rsp_miss_out,
  output logic mc_req_valid_out,
  output logic [ADDR_W-1:0] mc_req_addr_out,
  output logic mc_req_write_out,
  input wire logic mc_fill_valid_in,
  input wire logic [DATA_W-1:0] mc_fill_data_in,
  input wire logic mc_fill_shared_in,
  output logic probe_req_out,
  output logic [ADDR_W-1:0] probe_addr_out,
  input wire logic probe_done_in,
  output logic wb_valid_out,
  output logic [ADDR_W-1:0] wb_addr_out,
  output logic [DATA_W-1:0] wb_data_out
);
  localparam int NC = `VCCH_CORES;
  localparam int OFF = `VCCH_LINE_OFF_W;
  localparam int LA_W = ADDR_W - OFF;
  localparam int SW = `VCCH_STATE_W;
  localparam int E_W = SW + LA_W + DATA_W;
  localparam int I1 = $clog2(L1_LINES);
  localparam int I2 = $clog2(L2_LINES);
  localparam int I3 = $clog2(L3_LINES);

  logic rst_n;
  vcch_rst_sync u_rst (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .rst_n_out(rst_n)
  );

  function automatic vcch_pkg::vcch_moesi_t ent_st(input logic [E_W-1:0] e);
    return vcch_pkg::vcch_moesi_t'(e[E_W-1 -: SW]);
  endfunction
  function automatic logic [LA_W-1:0] ent_la(input logic [E_W-1:0] e);
    return e[DATA_W +: LA_W];
  endfunction
  function automatic logic [DATA_W-1:0] ent_dat(input logic [E_W-1:0] e);
    return e[DATA_W-1:0];
  endfunction

  logic [NC-1:0] l1_en, l1_we, l2_en, l2_we;
  logic [I1-1:0] l1_ad [NC];
  logic [I2-1:0] l2_ad [NC];
  logic [E_W-1:0] l1_wd [NC];
  logic [E_W-1:0] l2_wd [NC];
  logic [E_W-1:0] l1_rd [NC];
  logic [E_W-1:0] l2_rd [NC];
  logic l3_en, l3_we;
  logic [I3-1:0] l3_ad;
  logic [E_W-1:0] l3_wd, l3_rd;

  vcch_pkg::vcch_fsm_t st_q, st_d;
  vcch_pkg::vcch_op_t op_q, op_d;
  vcch_pkg::vcch_moesi_t new_st_q, new_st_d, rsp_st_q, rsp_st_d;
  logic [`VCCH_CORE_W-1:0] core_q, core_d;
  logic [LA_W-1:0] la_q, la_d, wb_la_q, wb_la_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, new_dat_q, new_dat_d, rsp_dat_q, rsp_dat_d, wb_dat_q, wb_dat_d;
  logic [E_W-1:0] vic_q, vic_d;
  logic [NC-1:0] inv1_q, inv1_d, inv2_q, inv2_d;
  logic inv3_q, inv3_d, miss_q, miss_d, rsp_v_q, rsp_v_d, wb_v_q, wb_v_d;
  logic [I3-1:0] init_q, init_d;

  // Private levels per core, one shared level
  for (genvar g = 0; g < NC; g++) begin : g_core
    vcch_line_ram #(.DEPTH(L1_LINES), .WIDTH(E_W)) u_l1 (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .en_in(l1_en[g]),
      .we_in(l1_we[g]),
      .addr_in(l1_ad[g]),
      .wdata_in(l1_wd[g]),
      .rdata_out(l1_rd[g])
    );
    vcch_line_ram #(.DEPTH(L2_LINES), .WIDTH(E_W)) u_l2 (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .en_in(l2_en[g]),
      .we_in(l2_we[g]),
      .addr_in(l2_ad[g]),
      .wdata_in(l2_wd[g]),
      .rdata_out(l2_rd[g])
    );
  end

  vcch_line_ram #(.DEPTH(L3_LINES), .WIDTH(E_W)) u_l3 (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .en_in(l3_en),
    .we_in(l3_we),
    .addr_in(l3_ad),
    .wdata_in(l3_wd),
    .rdata_out(l3_rd)
  );

  logic [NC-1:0] h1v, h2v, own_mask, oth1, oth2;
  logic h1, h2, h3, look_l3m;
  vcch_pkg::vcch_moesi_t s1, s2, s3;

  always_comb begin
    for (int k = 0; k < NC; k++) begin
      h1v[k] = ent_st(l1_rd[k]) != vcch_pkg::ST_I && ent_la(l1_rd[k]) == la_q;
      h2v[k] = ent_st(l2_rd[k]) != vcch_pkg::ST_I && ent_la(l2_rd[k]) == la_q;
    end
    own_mask = {{(NC-1){1'b0}}, 1'b1} << core_q;
    oth1 = h1v & ~own_mask;
    oth2 = h2v & ~own_mask;
    h1 = |(h1v & own_mask);
    h2 = |(h2v & own_mask);
    h3 = ent_st(l3_rd) != vcch_pkg::ST_I && ent_la(l3_rd) == la_q;
    s1 = ent_st(l1_rd[core_q]);
    s2 = ent_st(l2_rd[core_q]);
    s3 = ent_st(l3_rd);
    look_l3m = st_q == vcch_pkg::S_LOOK && !h1 && !h2 && h3 && s3 == vcch_pkg::ST_M;
  end

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    core_d = core_q;
    la_d = la_q;
    wdat_d = wdat_q;
    new_st_d = new_st_q;
    new_dat_d = new_dat_q;
    vic_d = vic_q;
    inv1_d = inv1_q;
    inv2_d = inv2_q;
    inv3_d = inv3_q;
    miss_d = miss_q;
    init_d = init_q;
    rsp_v_d = 1'b0;
    rsp_st_d = rsp_st_q;
    rsp_dat_d = rsp_dat_q;
    wb_v_d = 1'b0;
    wb_la_d = wb_la_q;
    wb_dat_d = wb_dat_q;
    l1_en = '0;
    l1_we = '0;
    l2_en = '0;
    l2_we = '0;
    l3_en = 1'b0;
    l3_we = 1'b0;
    l3_ad = la_q[I3-1:0];
    l3_wd = '0;
    for (int k = 0; k < NC; k++) begin
      l1_ad[k] = la_q[I1-1:0];
      l2_ad[k] = la_q[I2-1:0];
      l1_wd[k] = '0;
      l2_wd[k] = '0;
    end
    unique case (st_q)
      vcch_pkg::S_INIT: begin
        // Sweep every entry to invalid; the shared level is the deepest
        l1_en = '1;
        l1_we = '1;
        l2_en = '1;
        l2_we = '1;
        l3_en = 1'b1;
        l3_we = 1'b1;
        l3_ad = init_q;
        for (int k = 0; k < NC; k++) begin
          l1_ad[k] = init_q[I1-1:0];
          l2_ad[k] = init_q[I2-1:0];
        end
        init_d = I3'(init_q + 1'b1);
        if (&init_q) st_d = vcch_pkg::S_IDLE;
      end
      vcch_pkg::S_IDLE: begin
        if (req_valid_in) begin
          core_d = req_core_in;
          op_d = req_op_in;
          la_d = req_addr_in[ADDR_W-1:OFF];
          wdat_d = req_wdata_in;
          miss_d = 1'b0;
          l1_en = '1;
          l2_en = '1;
          l3_en = 1'b1;
          l3_ad = req_addr_in[OFF +: I3];
          for (int k = 0; k < NC; k++) begin
            l1_ad[k] = req_addr_in[OFF +: I1];
            l2_ad[k] = req_addr_in[OFF +: I2];
          end
          st_d = vcch_pkg::S_LOOK;
        end
      end
      vcch_pkg::S_LOOK: begin
        vic_d = (s1 != vcch_pkg::ST_I && !h1) ? l1_rd[core_q] : '0;
        inv1_d = oth1;
        inv2_d = oth2;
        inv3_d = h3;
        new_st_d = vcch_pkg::ST_M;
        if (h1) begin
          new_dat_d = op_q == vcch_pkg::OP_STORE ? wdat_q : ent_dat(l1_rd[core_q]);
          if (op_q == vcch_pkg::OP_LOAD) begin
            rsp_v_d = 1'b1;
            rsp_dat_d = ent_dat(l1_rd[core_q]);
            rsp_st_d = s1;
            st_d = vcch_pkg::S_IDLE;
          end else if (s1 == vcch_pkg::ST_M || s1 == vcch_pkg::ST_E) begin
            st_d = vcch_pkg::S_ALLOC;
          end else begin
            st_d = vcch_pkg::S_PROBE;
          end
        end else if (h2) begin
          l2_en[core_q] = 1'b1;
          l2_we[core_q] = 1'b1;
          new_dat_d = op_q == vcch_pkg::OP_STORE ? wdat_q : ent_dat(l2_rd[core_q]);
          if (op_q == vcch_pkg::OP_LOAD) begin
            new_st_d = s2;
            st_d = vcch_pkg::S_ALLOC;
          end else if (s2 == vcch_pkg::ST_M || s2 == vcch_pkg::ST_E) begin
            st_d = vcch_pkg::S_ALLOC;
          end else begin
            st_d = vcch_pkg::S_PROBE;
          end
        end else if (h3) begin
          new_dat_d = op_q == vcch_pkg::OP_STORE ? wdat_q : ent_dat(l3_rd);
          l3_en = 1'b1;
          l3_we = !(op_q == vcch_pkg::OP_LOAD && (s3 == vcch_pkg::ST_S || s3 == vcch_pkg::ST_O));
          l3_wd = l3_rd;
          st_d = vcch_pkg::S_ALLOC;
          if (op_q == vcch_pkg::OP_LOAD) begin
            new_st_d = vcch_pkg::ST_S;
            if (s3 == vcch_pkg::ST_M) begin
              l3_wd = {vcch_pkg::ST_O, ent_la(l3_rd), ent_dat(l3_rd)};
            end else if (s3 == vcch_pkg::ST_E) begin
              l3_wd = '0;
              new_st_d = vcch_pkg::ST_E;
            end
          end else if (s3 == vcch_pkg::ST_M || s3 == vcch_pkg::ST_E) begin
            l3_wd = '0;
          end else begin
            l3_we = 1'b0;
            l3_en = 1'b0;
            st_d = vcch_pkg::S_PROBE;
          end
        end else begin
          // Line absent here or held by another core's private levels
          miss_d = 1'b1;
          st_d = vcch_pkg::S_MISS;
        end
      end
      vcch_pkg::S_MISS: begin
        if (mc_fill_valid_in) begin
          new_dat_d = op_q == vcch_pkg::OP_STORE ? wdat_q : mc_fill_data_in;
          if (op_q == vcch_pkg::OP_LOAD) begin
            new_st_d = mc_fill_shared_in ? vcch_pkg::ST_S : vcch_pkg::ST_E;
            st_d = vcch_pkg::S_ALLOC;
          end else begin
            new_st_d = vcch_pkg::ST_M;
            st_d = (|inv1_q || |inv2_q || inv3_q) ? vcch_pkg::S_INVAL : vcch_pkg::S_ALLOC;
          end
        end
      end
      vcch_pkg::S_PROBE: begin
        if (probe_done_in) st_d = vcch_pkg::S_INVAL;
      end
      vcch_pkg::S_INVAL: begin
        // Writer ends up the sole holder
        l1_en = inv1_q;
        l1_we = inv1_q;
        l2_en = inv2_q;
        l2_we = inv2_q;
        l3_en = inv3_q;
        l3_we = inv3_q;
        st_d = vcch_pkg::S_ALLOC;
      end
      vcch_pkg::S_ALLOC: begin
        // Only the own first level takes the line; nothing is written through
        l1_en[core_q] = 1'b1;
        l1_we[core_q] = 1'b1;
        l1_wd[core_q] = {new_st_q, la_q, new_dat_q};
        if (ent_st(vic_q) != vcch_pkg::ST_I) begin
          l2_en[core_q] = 1'b1;
          l2_ad[core_q] = I2'(ent_la(vic_q));
          st_d = vcch_pkg::S_SPILL2;
        end else begin
          rsp_v_d = 1'b1;
          rsp_dat_d = new_dat_q;
          rsp_st_d = new_st_q;
          st_d = vcch_pkg::S_IDLE;
        end
      end
      vcch_pkg::S_SPILL2: begin
        l2_en[core_q] = 1'b1;
        l2_we[core_q] = 1'b1;
        l2_ad[core_q] = I2'(ent_la(vic_q));
        l2_wd[core_q] = vic_q;
        if (ent_st(l2_rd[core_q]) != vcch_pkg::ST_I) begin
          vic_d = l2_rd[core_q];
          l3_en = 1'b1;
          l3_ad = I3'(ent_la(l2_rd[core_q]));
          st_d = vcch_pkg::S_SPILL3;
        end else begin
          rsp_v_d = 1'b1;
          rsp_dat_d = new_dat_q;
          rsp_st_d = new_st_q;
          st_d = vcch_pkg::S_IDLE;
        end
      end
      vcch_pkg::S_SPILL3: begin
        // Only second-level victims ever land in the shared level
        l3_en = 1'b1;
        l3_we = 1'b1;
        l3_ad = I3'(ent_la(vic_q));
        l3_wd = vic_q;
        // Dirty lines leaving the hierarchy update memory
        if ((s3 == vcch_pkg::ST_M || s3 == vcch_pkg::ST_O) && ent_la(l3_rd) != ent_la(vic_q)) begin
          wb_v_d = 1'b1;
          wb_la_d = ent_la(l3_rd);
          wb_dat_d = ent_dat(l3_rd);
        end
        rsp_v_d = 1'b1;
        rsp_dat_d = new_dat_q;
        rsp_st_d = new_st_q;
        st_d = vcch_pkg::S_IDLE;
      end
      default: st_d = vcch_pkg::S_INIT;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= vcch_pkg::S_INIT;
      op_q <= vcch_pkg::OP_LOAD;
      core_q <= '0;
      la_q <= '0;
      wdat_q <= '0;
      new_st_q <= vcch_pkg::ST_I;
      new_dat_q <= '0;
      vic_q <= '0;
      inv1_q <= '0;
      inv2_q <= '0;
      inv3_q <= 1'b0;
      miss_q <= 1'b0;
      init_q <= '0;
      rsp_v_q <= 1'b0;
      rsp_st_q <= vcch_pkg::ST_I;
      rsp_dat_q <= '0;
      wb_v_q <= 1'b0;
      wb_la_q <= '0;
      wb_dat_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      core_q <= core_d;
      la_q <= la_d;
      wdat_q <= wdat_d;
      new_st_q <= new_st_d;
      new_dat_q <= new_dat_d;
      vic_q <= vic_d;
      inv1_q <= inv1_d;
      inv2_q <= inv2_d;
      inv3_q <= inv3_d;
      miss_q <= miss_d;
      init_q <= init_d;
      rsp_v_q <= rsp_v_d;
      rsp_st_q <= rsp_st_d;
      rsp_dat_q <= rsp_dat_d;
      wb_v_q <= wb_v_d;
      wb_la_q <= wb_la_d;
      wb_dat_q <= wb_dat_d;
    end
  end

  assign req_ready_out = st_q == vcch_pkg::S_IDLE;
  assign rsp_valid_out = rsp_v_q;
  assign rsp_core_out = core_q;
  assign rsp_data_out = rsp_dat_q;
  assign rsp_state_out = rsp_st_q;
  assign rsp_miss_out = miss_q;
  assign mc_req_valid_out = st_q == vcch_pkg::S_MISS;
  assign mc_req_addr_out = {la_q, {OFF{1'b0}}};
  assign mc_req_write_out = op_q != vcch_pkg::OP_LOAD;
  assign probe_req_out = st_q == vcch_pkg::S_PROBE;
  assign probe_addr_out = {la_q, {OFF{1'b0}}};
  assign wb_valid_out = wb_v_q;
  assign wb_addr_out = {wb_la_q, {OFF{1'b0}}};
  assign wb_data_out = wb_dat_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_probe_end;
    probe_req_out && probe_done_in;
  endsequence
  sequence s_own_mod_write;
    st_q == vcch_pkg::S_INVAL ##1 (l1_we[core_q] && ent_st(l1_wd[core_q]) == vcch_pkg::ST_M);
  endsequence

  probe_hold_a: assert property (probe_req_out && !probe_done_in |=> probe_req_out)
    else $error("probe request dropped before done");
  probe_cause_a: assert property ($rose(probe_req_out) |-> op_q != vcch_pkg::OP_LOAD)
    else $error("probe raised for a load");
  probe_to_mod_a: assert property (s_probe_end |=> s_own_mod_write)
    else $error("writer not modified after probes");
  l3_fill_a: assert property (l3_we && st_q != vcch_pkg::S_SPILL3 |->
    ent_st(l3_wd) inside {vcch_pkg::ST_I, vcch_pkg::ST_O})
    else $error("shared level filled outside spill");
  store_mod_a: assert property (rsp_valid_out && op_q != vcch_pkg::OP_LOAD |-> rsp_state_out == vcch_pkg::ST_M)
    else $error("write answered without modified state");
  read_owned_a: assert property (look_l3m && op_q == vcch_pkg::OP_LOAD |->
    (l3_we && ent_st(l3_wd) == vcch_pkg::ST_O) ##[2:4] (rsp_valid_out && rsp_state_out == vcch_pkg::ST_S))
    else $error("read of modified shared line mishandled");
  wip_move_a: assert property (look_l3m && op_q == vcch_pkg::OP_WRITE_INTENT_PREFETCH |->
    (l3_we && ent_st(l3_wd) == vcch_pkg::ST_I) ##[2:4] (rsp_valid_out && rsp_state_out == vcch_pkg::ST_M))
    else $error("write intent prefetch did not move line");
  store_noprobe_a: assert property (look_l3m && op_q == vcch_pkg::OP_STORE |=> (!probe_req_out) [*3])
    else $error("probe on modified shared line");
  migr_miss_a: assert property (st_q == vcch_pkg::S_LOOK && !h1 && !h2 && !h3 && |(oth1 | oth2)
    |=> mc_req_valid_out && rsp_miss_out)
    else $error("migrated line not sent to memory controller");
  wb_dirty_a: assert property (wb_valid_out |-> $past(st_q) == vcch_pkg::S_SPILL3)
    else $error("writeback outside shared eviction");
  victim_chain_a: assert property (st_q == vcch_pkg::S_ALLOC && ent_st(vic_q) != vcch_pkg::ST_I
    |=> st_q == vcch_pkg::S_SPILL2 ##0 l2_we[core_q])
    else $error("first-level victim not spilled");
  excl_load_a: assert property (rsp_valid_out && rsp_state_out == vcch_pkg::ST_E |-> op_q == vcch_pkg::OP_LOAD)
    else $error("exclusive answer for a write");
endmodule

// >>> vcch_mc_model.sv
`timescale 1ns/1ps
module vcch_mc_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic shared_mode_in,
  input wire logic mc_req_valid_in,
  input wire logic probe_req_in,
  output logic fill_valid_out,
  output logic [31:0] fill_data_out,
  output logic fill_shared_out,
  output logic probe_done_out,
  output logic [31:0] last_fill_out
);
  // Waits alternate short and long so both prompt and slow answers are seen
  logic [2:0] wait_q;
  logic slow_q;
  logic shared_q;
  logic [31:0] seq_q;

  // Between pulses the lines show the inverse of the last value, never a stale copy
  assign fill_data_out = fill_valid_out ? last_fill_out : ~last_fill_out;
  assign fill_shared_out = fill_valid_out ? shared_q : ~shared_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 3'h0;
      slow_q <= 1'b0;
      shared_q <= 1'b0;
      seq_q <= 32'h1234_0001;
      fill_valid_out <= 1'b0;
      probe_done_out <= 1'b0;
      last_fill_out <= 32'h0;
    end else begin
      fill_valid_out <= 1'b0;
      probe_done_out <= 1'b0;
      seq_q <= seq_q + 32'h0101_0011;
      if ((mc_req_valid_in || probe_req_in) && !fill_valid_out && !probe_done_out) begin
        if (wait_q == 3'h0) begin
          fill_valid_out <= mc_req_valid_in;
          probe_done_out <= probe_req_in;
          if (mc_req_valid_in) begin
            last_fill_out <= seq_q;
          end
          shared_q <= shared_mode_in;
          slow_q <= ~slow_q;
          wait_q <= slow_q ? 3'h1 : 3'h5;
        end else begin
          wait_q <= wait_q - 3'h1;
        end
      end
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk_in, reset_n_in, req_valid_in, shared_mode;
  logic [1:0] req_core_in, rsp_core_out;
  vcch_pkg::vcch_op_t req_op_in;
  vcch_pkg::vcch_moesi_t rsp_state_out;
  logic [31:0] req_addr_in, req_wdata_in, rsp_data_out, mc_req_addr_out, mc_fill_data_in;
  logic [31:0] probe_addr_out, wb_addr_out, wb_data_out, last_fill, saw_mc_addr;
  logic req_ready_out, rsp_valid_out, rsp_miss_out, mc_req_valid_out, mc_req_write_out;
  logic probe_req_out, wb_valid_out, mc_fill_valid_in, mc_fill_shared_in, probe_done_in;
  logic saw_probe, saw_wb, saw_mcw;
  int errors, tests_run;

  // Small levels keep the init sweep and victim chains short
  vcch_top #(.L1_LINES(4), .L2_LINES(8), .L3_LINES(16)) uut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_core_in(req_core_in), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .rsp_valid_out(rsp_valid_out),
    .rsp_core_out(rsp_core_out), .rsp_data_out(rsp_data_out), .rsp_state_out(rsp_state_out),
    .rsp_miss_out(rsp_miss_out), .mc_req_valid_out(mc_req_valid_out), .mc_req_addr_out(mc_req_addr_out),
    .mc_req_write_out(mc_req_write_out), .mc_fill_valid_in(mc_fill_valid_in),
    .mc_fill_data_in(mc_fill_data_in), .mc_fill_shared_in(mc_fill_shared_in),
    .probe_req_out(probe_req_out), .probe_addr_out(probe_addr_out), .probe_done_in(probe_done_in),
    .wb_valid_out(wb_valid_out), .wb_addr_out(wb_addr_out), .wb_data_out(wb_data_out));

  vcch_mc_model mc (
    .clk_in(sys_clk_in), .rst_n_in(reset_n_in), .shared_mode_in(shared_mode),
    .mc_req_valid_in(mc_req_valid_out), .probe_req_in(probe_req_out), .fill_valid_out(mc_fill_valid_in),
    .fill_data_out(mc_fill_data_in), .fill_shared_out(mc_fill_shared_in),
    .probe_done_out(probe_done_in), .last_fill_out(last_fill));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_rsp(input vcch_pkg::vcch_moesi_t st, input logic miss);
    check({28'h0, rsp_miss_out, rsp_state_out}, {28'h0, miss, st});
  endtask

  // Store data is derived from the address so every line carries a known word
  task automatic access(input logic [1:0] core, input vcch_pkg::vcch_op_t op, input logic [31:0] addr);
    int n;
    saw_probe = 1'b0;
    saw_wb = 1'b0;
    saw_mcw = 1'b0;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_core_in <= core;
    req_op_in <= op;
    req_addr_in <= addr;
    req_wdata_in <= addr ^ 32'ha5a5_0000;
    @(negedge sys_clk_in);
    for (n = 0; n < 500 && req_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
      if (probe_req_out === 1'b1) saw_probe = 1'b1;
      if (wb_valid_out === 1'b1) saw_wb = 1'b1;
      if (mc_req_valid_out === 1'b1) begin
        saw_mcw = mc_req_write_out;
        saw_mc_addr = mc_req_addr_out;
      end
    end while (rsp_valid_out !== 1'b1 && n < 500);
    if (n >= 500) begin
      errors++;
      complete_run;
    end
  endtask

  // Three stores on one first-level index push the first line out to the shared level
  task automatic spill(input logic [1:0] core, input logic [31:0] line);
    for (int k = 0; k < 3; k++) access(core, vcch_pkg::OP_STORE, (line + 32'(8 * k)) << 6);
  endtask

  task automatic t_store;
    access(2'h0, vcch_pkg::OP_STORE, 32'h0000_0004);
    expect_rsp(vcch_pkg::ST_M, 1'b1);
    check(saw_mc_addr, 32'h0);
    check({31'h0, saw_mcw}, 32'h1);
    access(2'h0, vcch_pkg::OP_LOAD, 32'h0000_0000);
    expect_rsp(vcch_pkg::ST_M, 1'b0);
    check(rsp_data_out, 32'ha5a5_0004);
    access(2'h0, vcch_pkg::OP_STORE, 32'h0000_0180);
    access(2'h1, vcch_pkg::OP_LOAD, 32'h0000_0180);
    check({31'h0, rsp_miss_out}, 32'h1);
    $display("test store done");
  endtask

  task automatic t_fill;
    shared_mode = 1'b0;
    access(2'h2, vcch_pkg::OP_LOAD, 32'h0000_1000);
    expect_rsp(vcch_pkg::ST_E, 1'b1);
    check(rsp_data_out, last_fill);
    shared_mode = 1'b1;
    access(2'h2, vcch_pkg::OP_LOAD, 32'h0000_2000);
    expect_rsp(vcch_pkg::ST_S, 1'b1);
    shared_mode = 1'b0;
    $display("test fill done");
  endtask

  task automatic t_victim;
    spill(2'h0, 32'd5);
    access(2'h1, vcch_pkg::OP_LOAD, 32'h0000_0140);
    expect_rsp(vcch_pkg::ST_S, 1'b0);
    check({30'h0, rsp_core_out}, 32'h1);
    check(rsp_data_out, 32'ha5a5_0140);
    access(2'h2, vcch_pkg::OP_LOAD, 32'h0000_0140);
    expect_rsp(vcch_pkg::ST_S, 1'b0);
    access(2'h0, vcch_pkg::OP_STORE, 32'h0000_0140);
    check({31'h0, saw_probe}, 32'h1);
    check(probe_addr_out, 32'h0000_0140);
    expect_rsp(vcch_pkg::ST_M, 1'b0);
    access(2'h1, vcch_pkg::OP_LOAD, 32'h0000_0140);
    check({31'h0, rsp_miss_out}, 32'h1);
    $display("test victim done");
  endtask

  task automatic t_prefetch;
    spill(2'h2, 32'd2);
    access(2'h3, vcch_pkg::OP_WRITE_INTENT_PREFETCH, 32'h0000_0080);
    expect_rsp(vcch_pkg::ST_M, 1'b0);
    check({31'h0, saw_probe}, 32'h0);
    check(rsp_data_out, 32'ha5a5_0080);
    access(2'h2, vcch_pkg::OP_STORE, 32'h0000_0080);
    expect_rsp(vcch_pkg::ST_M, 1'b1);
    spill(2'h3, 32'd7);
    access(2'h1, vcch_pkg::OP_STORE, 32'h0000_01c0);
    check({31'h0, saw_probe}, 32'h0);
    expect_rsp(vcch_pkg::ST_M, 1'b0);
    $display("test prefetch done");
  endtask

  task automatic t_wb;
    spill(2'h0, 32'd3);
    spill(2'h0, 32'd19);
    check({31'h0, saw_wb}, 32'h1);
    check(wb_addr_out, 32'h0000_00c0);
    check(wb_data_out, 32'ha5a5_00c0);
    $display("test writeback done");
  endtask

  initial begin
    reset_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_core_in = 2'h0;
    req_op_in = vcch_pkg::OP_LOAD;
    req_addr_in = 32'h0;
    req_wdata_in = 32'h0;
    shared_mode = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_store;
    t_fill;
    t_victim;
    t_prefetch;
    t_wb;
    complete_run;
  end

  // The 28 requests of at most about a dozen cycles each fit well inside this span
  initial begin
    #40000;
    errors++;
    complete_run;
  end
endmodule
